// ===== include/ecsr_pkg.sv
// Constants, field positions and cycle codes of the memory control and status unit.
// Notes on behaviour
// - Three select inputs decode into eight cycle types.
// - A cycle starts only while the strobe is high with the select code held.
// - Init without strobe clears every bit shown on the status port.
// - Init with strobe drives zeros onto the memory data bus.
// - Capture cycle latches 11 address bits as the strobe falls.
// - Log cycles copy temporary address to error address per bits 2 and 15.
// - Read bits 5-11 come from error address or syndrome per bits 2 and 14.
// - Read bit 11 is one when bits 2, 13 and 14 are all set.
// - Status bits 0-4 and 13-15 load on writes and return on reads.
// - Status bits 0, 1, 2, 3, 13 and 15 appear on the status port.
// - Single log sets bit 4, double log sets bit 15.
// - Syndrome loads from check bus on syndrome-in, data bits 5-10 on diagnostic write.
// - Diagnostic register loads data bits 5-10 on writes, drives check bus on diagnostic out.
// - Syndrome also loads from check bus on log cycles while bit 2 is clear.
// - With bit 2 set a read returns the syndrome in bits 5-10.
package ecsr_pkg;

	localparam int ADDR_W = 11;
	localparam int DATA_W = 16;
	localparam int CB_W = 6;
	localparam int STAT_W = 6;

	// Cycle codes in the order hi, mid, lo.
	typedef enum logic [2:0] {
		ECSR_SYN_IN = 3'h0,
		ECSR_DBL_LOG = 3'h1,
		ECSR_SGL_LOG = 3'h2,
		ECSR_DIAG_OUT = 3'h3,
		ECSR_WR_DIAG = 3'h4,
		ECSR_WRITE = 3'h5,
		ECSR_READ = 3'h6,
		ECSR_CAP_ADDR = 3'h7
	} ecsr_op_t;

	// Field positions inside the register word.
	localparam int B_SGL_ERR = 4;
	localparam int B_LOG_OFF = 2;
	localparam int B_ALT = 13;
	localparam int B_HI_ADDR = 14;
	localparam int B_DBL_ERR = 15;
	localparam int F_MUX_LO = 5;
	localparam int F_MUX_HI = 11;
	localparam int F_CB_HI = 10;

	localparam logic [15:0] STATUS_MASK = 16'he01f;
	localparam logic [15:0] STATUS_PORT_MASK = 16'ha00f;
	localparam logic [15:0] CSR_RESET = 16'h0000;
	localparam logic [5:0] CB_RESET = 6'h00;
	localparam logic [10:0] ADDR_RESET = 11'h000;

endpackage

// ===== include/ecsr_op_if.sv
// Decoded cycle request passed from the cycle decoder to the register core.
`timescale 1ns/10ps
interface ecsr_op_if;
	logic go;
	ecsr_pkg::ecsr_op_t op;
	modport dec (output go, output op);
	modport core (input go, input op);
endinterface

// ===== design/ecsr_decode.sv
// Cycle decoder: turns the strobe and select lines into a cycle request.
`timescale 1ns/10ps
module ecsr_decode (
	input wire logic cycle_select_hi,
	input wire logic cycle_select_mid,
	input wire logic cycle_select_lo,
	input wire logic cycle_strobe,
	input wire logic init,
	ecsr_op_if.dec dif
);
	import ecsr_pkg::*;

	// The strobe enables the decoder; init with strobe is zeroing, not a cycle.
	always_comb begin
		dif.go = cycle_strobe & ~init;
		dif.op = ecsr_op_t'({cycle_select_hi, cycle_select_mid, cycle_select_lo});
	end

endmodule // ecsr_decode

// ===== design/ecsr_unit.sv
// Register core of the memory control and status unit with its bus drivers.
`timescale 1ns/10ps
module ecsr_unit (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic cycle_select_hi,
	input wire logic cycle_select_mid,
	input wire logic cycle_select_lo,
	input wire logic cycle_strobe,
	input wire logic init,
	input wire logic [ecsr_pkg::ADDR_W-1:0] mem_addr,
	input wire logic [ecsr_pkg::DATA_W-1:0] data_in,
	output logic [ecsr_pkg::DATA_W-1:0] data_out,
	output logic [ecsr_pkg::DATA_W-1:0] data_oe,
	input wire logic [ecsr_pkg::CB_W-1:0] checkbit_syndrome_in,
	output logic [ecsr_pkg::CB_W-1:0] checkbit_syndrome_out,
	output logic [ecsr_pkg::CB_W-1:0] checkbit_syndrome_oe,
	output logic [ecsr_pkg::STAT_W-1:0] status_out
);
	import ecsr_pkg::*;

	typedef struct packed {
		logic strobe_q;
		ecsr_op_t op_q;
		logic [ADDR_W-1:0] addr_q;
		logic [ADDR_W-1:0] tmp_addr;
		logic [ADDR_W-1:0] err_addr;
		logic [DATA_W-1:0] memory_control_status;
		logic [CB_W-1:0] syn;
		logic [CB_W-1:0] diag;
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] doe;
		logic [CB_W-1:0] cbout;
		logic [CB_W-1:0] cboe;
		logic [STAT_W-1:0] stat;
	} ecsr_state_t;

	ecsr_state_t s;
	ecsr_state_t next_s;
	logic start;
	logic fall;
	// Data bus field that feeds the diagnostic register on writes and the syndrome register on diagnostic writes.
	logic [CB_W-1:0] wr_field;

	ecsr_op_if dif ();

	ecsr_decode u_decode (
		.cycle_select_hi(cycle_select_hi),
		.cycle_select_mid(cycle_select_mid),
		.cycle_select_lo(cycle_select_lo),
		.cycle_strobe(cycle_strobe),
		.init(init),
		.dif(dif)
	);

	// Builds the word returned on a read from status, error address and syndrome.
	function automatic logic [DATA_W-1:0] read_word(
		input logic [DATA_W-1:0] memory_control_status,
		input logic [ADDR_W-1:0] ea,
		input logic [CB_W-1:0] syn
	);
		logic [DATA_W-1:0] w;
		w = memory_control_status & STATUS_MASK;
		if (memory_control_status[B_LOG_OFF]) begin
			w[F_CB_HI:F_MUX_LO] = syn;
			w[F_MUX_HI] = memory_control_status[B_ALT] & memory_control_status[B_HI_ADDR];
		end else if (memory_control_status[B_HI_ADDR]) begin
			w[F_MUX_HI:F_MUX_LO] = {3'h0, ea[10:7]};
		end else begin
			w[F_MUX_HI:F_MUX_LO] = ea[6:0];
		end
		return w;
	endfunction

	// Strobe rise starts a cycle; strobe fall closes it.
	assign start = dif.go & ~s.strobe_q;
	assign fall = s.strobe_q & ~cycle_strobe;
	assign wr_field = data_in[F_CB_HI:F_MUX_LO];

	// Next state of every register and bus driver.
	always_comb begin
		next_s = s;
		next_s.strobe_q = cycle_strobe;
		next_s.addr_q = mem_addr;
		if (start) begin
			next_s.op_q = dif.op;
		end
		// A zeroing strobe is no cycle, so an old capture must not fire at its fall.
		if (cycle_strobe && init && !s.strobe_q) begin
			next_s.op_q = ECSR_READ;
		end
		// Address seen in the last strobe-high cycle is taken as it falls.
		if (fall && s.op_q == ECSR_CAP_ADDR) begin
			next_s.tmp_addr = s.addr_q;
		end
		if (init && !cycle_strobe) begin
			next_s.memory_control_status = s.memory_control_status & ~STATUS_PORT_MASK;
		end
		if (start) begin
			case (dif.op)
				ECSR_SYN_IN: begin
					next_s.syn = checkbit_syndrome_in;
				end
				ECSR_DBL_LOG, ECSR_SGL_LOG: begin
					if (!s.memory_control_status[B_LOG_OFF]) begin
						next_s.syn = checkbit_syndrome_in;
						if (dif.op == ECSR_DBL_LOG || !s.memory_control_status[B_DBL_ERR]) begin
							next_s.err_addr = s.tmp_addr;
						end
					end
					if (dif.op == ECSR_SGL_LOG) begin
						next_s.memory_control_status[B_SGL_ERR] = 1'b1;
					end else begin
						next_s.memory_control_status[B_DBL_ERR] = 1'b1;
					end
				end
				ECSR_WR_DIAG: begin
					next_s.memory_control_status = data_in & STATUS_MASK;
					next_s.diag = data_in[F_CB_HI:F_MUX_LO];
					next_s.syn = data_in[F_CB_HI:F_MUX_LO];
				end
				ECSR_WRITE: begin
					next_s.memory_control_status = data_in & STATUS_MASK;
					next_s.diag = data_in[F_CB_HI:F_MUX_LO];
				end
				default: begin
					next_s.op_q = dif.op;
				end
			endcase
		end
		// Bus drivers float unless a read, zeroing or diagnostic out is active.
		next_s.doe = '0;
		next_s.dout = '0;
		next_s.cboe = '0;
		next_s.cbout = '0;
		if (cycle_strobe && init) begin
			next_s.doe = '1;
		end else if (dif.go && dif.op == ECSR_READ) begin
			next_s.doe = '1;
			next_s.dout = read_word(s.memory_control_status, s.err_addr, s.syn);
		end
		if (dif.go && dif.op == ECSR_DIAG_OUT) begin
			next_s.cboe = '1;
			next_s.cbout = s.diag;
		end
		next_s.stat = {next_s.memory_control_status[15], next_s.memory_control_status[13], next_s.memory_control_status[3:0]};
	end

	// State register.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '{strobe_q: 1'b0, op_q: ECSR_SYN_IN, addr_q: ADDR_RESET,
				tmp_addr: ADDR_RESET, err_addr: ADDR_RESET, memory_control_status: CSR_RESET,
				syn: CB_RESET, diag: CB_RESET, dout: CSR_RESET, doe: CSR_RESET,
				cbout: CB_RESET, cboe: CB_RESET, stat: '0};
		end else begin
			s <= next_s;
		end
	end

	// Outputs come straight from the state flops.
	assign data_out = s.dout;
	assign data_oe = s.doe;
	assign checkbit_syndrome_out = s.cbout;
	assign checkbit_syndrome_oe = s.cboe;
	assign status_out = s.stat;

	a_init_clears_port: assert property (@(posedge core_clk) disable iff (!reset_n)
		init && !cycle_strobe |=> status_out == 6'h00)
		else $error("status port not cleared by init");
	a_zero_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
		init && cycle_strobe |=> data_oe == 16'hffff && data_out == 16'h0000)
		else $error("init with strobe did not drive zeros");
	a_bus_release: assert property (@(posedge core_clk) disable iff (!reset_n)
		!cycle_strobe |=> data_oe == 16'h0000 && checkbit_syndrome_oe == 6'h00)
		else $error("bus driven outside a cycle");
	a_diag_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
		dif.go && dif.op == ECSR_DIAG_OUT
		|=> checkbit_syndrome_oe == 6'h3f && checkbit_syndrome_out == $past(s.diag))
		else $error("diagnostic register not driven");
	a_single_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && dif.op == ECSR_SGL_LOG |=> s.memory_control_status[B_SGL_ERR]
		##1 (status_out == $past(status_out) || $past(init)))
		else $error("single error flag not set");
	a_double_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && dif.op == ECSR_DBL_LOG && !init
		|=> status_out[5] ##1 (status_out[5] || $past(init)))
		else $error("double error flag not shown");
	a_tmp_capture: assert property (@(posedge core_clk) disable iff (!reset_n)
		fall && s.op_q == ECSR_CAP_ADDR |=> s.tmp_addr == $past(s.addr_q))
		else $error("temporary address not captured");
	a_log_locked: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && (dif.op == ECSR_SGL_LOG || dif.op == ECSR_DBL_LOG) && s.memory_control_status[B_LOG_OFF]
		|=> $stable(s.err_addr) && $stable(s.syn))
		else $error("error address moved while logging is off");
	a_syn_in: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && dif.op == ECSR_SYN_IN |=> s.syn == $past(checkbit_syndrome_in))
		else $error("syndrome not loaded from check bus");
	a_read_bit11: assert property (@(posedge core_clk) disable iff (!reset_n)
		dif.go && dif.op == ECSR_READ && s.memory_control_status[B_LOG_OFF] && s.memory_control_status[B_ALT] && s.memory_control_status[B_HI_ADDR]
		|=> data_out[11] && data_oe[11])
		else $error("read bit 11 not forced to one");

	// Register loads and read sources that the bus checks above do not cover.
	a_write_store: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && (dif.op == ECSR_WRITE || dif.op == ECSR_WR_DIAG)
		|=> s.memory_control_status == ($past(data_in) & STATUS_MASK) && s.diag == $past(wr_field))
		else $error("write did not load status and diagnostic registers");
	a_diag_syn: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && dif.op == ECSR_WR_DIAG |=> s.syn == $past(wr_field))
		else $error("diagnostic write did not load the syndrome");
	a_log_syn: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && (dif.op == ECSR_SGL_LOG || dif.op == ECSR_DBL_LOG) && !s.memory_control_status[B_LOG_OFF]
		|=> s.syn == $past(checkbit_syndrome_in))
		else $error("log cycle did not load the syndrome");
	a_log_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
		start && !s.memory_control_status[B_LOG_OFF]
		&& (dif.op == ECSR_DBL_LOG || (dif.op == ECSR_SGL_LOG && !s.memory_control_status[B_DBL_ERR]))
		|=> s.err_addr == $past(s.tmp_addr))
		else $error("log cycle did not copy the temporary address");
	a_read_syn: assert property (@(posedge core_clk) disable iff (!reset_n)
		dif.go && dif.op == ECSR_READ && s.memory_control_status[B_LOG_OFF]
		|=> data_out[F_CB_HI:F_MUX_LO] == $past(s.syn))
		else $error("read did not return the syndrome");
	a_read_hi: assert property (@(posedge core_clk) disable iff (!reset_n)
		dif.go && dif.op == ECSR_READ && !s.memory_control_status[B_LOG_OFF] && s.memory_control_status[B_HI_ADDR]
		|=> data_out[F_MUX_HI:F_MUX_HI-2] == 3'h0)
		else $error("high address read has stray upper bits");
	a_no_cycle_init: assert property (@(posedge core_clk) disable iff (!reset_n)
		init && cycle_strobe |=> $stable(s.memory_control_status) && $stable(s.syn) && $stable(s.diag))
		else $error("zeroing strobe changed a register");

endmodule // ecsr_unit

// ===== tb/ecsr_edc_model.sv
// Behavioural model of the error correction logic on the check bit bus.
`timescale 1ns/10ps
module ecsr_edc_model (
	input wire logic core_clk,
	input wire logic drv,
	input wire logic [5:0] val,
	input wire logic [5:0] unit_out,
	input wire logic [5:0] unit_oe,
	output logic [5:0] bus
);
	logic [5:0] last = 6'h00;
	// The unit wins where it drives; a released bus keeps changing.
	always_comb begin
		for (int b = 0; b < 6; b++) begin
			bus[b] = unit_oe[b] ? unit_out[b] : (drv ? val[b] : ~last[b]);
		end
	end
	// Remember the level so an idle bus toggles every cycle.
	always @(posedge core_clk) begin
		last <= bus;
	end
endmodule // ecsr_edc_model

// ===== tb/ecsr_unit_test.sv
// Self-checking bench of the memory control and status unit.
`timescale 1ns/10ps
module ecsr_unit_test;
	import ecsr_pkg::*;
	logic core_clk = 0, reset_n = 0, strobe = 0, init = 0, edc_drv = 0;
	logic [2:0] code = 0;
	logic [10:0] addr = 0, tmp = 0, ea = 0;
	logic [15:0] din = 0, dout, doe, st = 0;
	logic [5:0] cb_bus, cb_out, cb_oe, edc_val = 0, syn = 0, diag = 0, stat;
	integer failures = 0, samples_checked = 0, seed = 32'h9221, ticks = 0, i;
	ecsr_unit dut_u (.core_clk(core_clk), .reset_n(reset_n), .cycle_select_hi(code[2]),
		.cycle_select_mid(code[1]), .cycle_select_lo(code[0]), .cycle_strobe(strobe),
		.init(init), .mem_addr(addr), .data_in(din), .data_out(dout), .data_oe(doe),
		.checkbit_syndrome_in(cb_bus), .checkbit_syndrome_out(cb_out),
		.checkbit_syndrome_oe(cb_oe), .status_out(stat));
	ecsr_edc_model edc_u (.core_clk(core_clk), .drv(edc_drv), .val(edc_val),
		.unit_out(cb_out), .unit_oe(cb_oe), .bus(cb_bus));
	// Clock and hang guard.
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		ticks++;
		if (ticks == 20000) begin
			failures++;
			final_report;
		end
	end
	// Prints the verdict and stops.
	task final_report;
		if (failures == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// One comparison.
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask
	// Expected read word from the reference state.
	function automatic logic [15:0] rd_word();
		logic [15:0] w;
		w = st;
		if (st[2]) w[11:5] = {st[13] & st[14], syn};
		else if (st[14]) w[11:5] = {3'h0, ea[10:7]};
		else w[11:5] = ea[6:0];
		return w;
	endfunction
	// Reference state update for one started cycle.
	task model_cycle(input logic [2:0] c);
		case (c)
			3'h0: syn = edc_val;
			3'h1: begin
				if (!st[2]) begin
					ea = tmp;
					syn = edc_val;
				end
				st[15] = 1'b1;
			end
			3'h2: begin
				if (!st[2] && !st[15]) ea = tmp;
				if (!st[2]) syn = edc_val;
				st[4] = 1'b1;
			end
			3'h4, 3'h5: begin
				st = din & STATUS_MASK;
				diag = din[10:5];
				if (c == 3'h4) syn = din[10:5];
			end
			3'h7: tmp = addr;
			default: ;
		endcase
	endtask
	// Strobe one cycle, check the answer, then release and check idle.
	task run_cycle(input logic [2:0] c, input logic ini);
		@(posedge core_clk);
		code <= c;
		init <= ini;
		strobe <= 1'b1;
		edc_drv <= (c <= 3'h2);
		@(posedge core_clk);
		#1;
		if (ini) begin
			chk("zero data", 16'h0, dout);
			chk("zero oe", 16'hffff, doe);
		end else begin
			if (c == 3'h6) chk("read word", rd_word(), dout);
			if (c == 3'h6) chk("read oe", 16'hffff, doe);
			if (c == 3'h3) chk("diag bus", {10'h0, diag}, {10'h0, cb_out});
			if (c == 3'h3) chk("diag oe", 16'h3f, {10'h0, cb_oe});
			model_cycle(c);
		end
		@(posedge core_clk);
		strobe <= 1'b0;
		edc_drv <= 1'b0;
		init <= 1'b0;
		@(posedge core_clk);
		#1;
		chk("idle oe", 16'h0, doe | {10'h0, cb_oe});
		chk("status", {10'h0, st[15], st[13], st[3:0]}, {10'h0, stat});
	endtask
	// Reset, corner cases, then random cycles.
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		run_cycle(3'h6, 1'b0);
		run_cycle(3'h5, 1'b1);
		for (i = 0; i < 400; i++) begin
			@(posedge core_clk);
			din <= 16'($random(seed));
			edc_val <= 6'($random(seed));
			addr <= 11'($random(seed));
			if (($random(seed) & 15) == 0) begin
				init <= 1'b1;
				@(posedge core_clk);
				init <= 1'b0;
				st = st & ~STATUS_PORT_MASK;
				repeat (2) @(posedge core_clk);
				#1;
				chk("init status", 16'h0, {10'h0, stat});
			end else begin
				run_cycle(3'($random(seed)), ($random(seed) & 15) == 0);
			end
		end
		final_report;
	end
endmodule // ecsr_unit_test
